// [comparator_pkg.sv]
// constants for the comparator control block: register map, fields, timing
// assumes a byte-wide register port and a 125 MHz peripheral clock
package comparator_pkg;
    // =====================================================================
    // register offsets
    localparam logic [2:0] COMPARATOR_CONTROL_OFS     = 3'h0;
    localparam logic [2:0] INPUT_SELECTOR_CONTROL_OFS = 3'h2;
    localparam logic [2:0] INTERRUPT_ENABLE_REG_OFS   = 3'h6;
    localparam logic [2:0] STATUS_OFS                 = 3'h7;
    localparam logic [2:0] SLEEP_CONTROL_OFS          = 3'h4;
    // =====================================================================
    // field positions
    localparam int ENABLE_BIT   = 0;
    localparam int HYST_LSB     = 1;
    localparam int EDGE_LSB     = 4;
    localparam int PADOUT_BIT   = 6;
    localparam int STANDBY_BIT  = 7;
    localparam int NEGSEL_LSB   = 0;
    localparam int POSSEL_BIT   = 3;
    localparam int INVERT_BIT   = 7;
    localparam int FLAG_BIT     = 0;
    localparam int STATE_BIT    = 4;
    localparam int SLEEP_LSB    = 0;
    localparam int DEBUG_BIT    = 2;
    // =====================================================================
    // reset values and masks
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_MASK   = 8'hf7;
    localparam logic [7:0] SELECTOR_RESET = 8'h00;
    localparam logic [7:0] SELECTOR_MASK  = 8'h8b;
    localparam logic [7:0] SLEEP_RESET    = 8'h00;
    // =====================================================================
    // encodings
    localparam logic [1:0] EDGE_ANY     = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING  = 2'h3;
    localparam logic [1:0] NEG_PIN0     = 2'h0;
    localparam logic [1:0] NEG_PIN1     = 2'h1;
    localparam logic [1:0] NEG_REF      = 2'h2;
    localparam logic [7:0] COMPARATOR_IRQ_VECTOR = 8'h00;
    typedef enum logic [1:0] {
        SLEEP_ACTIVE    = 2'b00,
        SLEEP_IDLE      = 2'b01,
        SLEEP_STANDBY   = 2'b10,
        SLEEP_POWERDOWN = 2'b11
    } sleep_type;
    // =====================================================================
    // timing
    localparam int CLK_MHZ          = 125;
    localparam int STARTUP_NS       = 2500;
    localparam int REF_STARTUP_NS   = 60000;
    localparam int STARTUP_CYCLES     = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_STARTUP_CYCLES = (REF_STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_STAGES      = 3;
endpackage

// [level_synchronizer.sv]
// multi-stage synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk
`timescale 1ns/1ns
module level_synchronizer #(
    parameter int STAGES = 3
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic [STAGES-1:0] chain_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            chain_r <= '0;
        else
            chain_r <= {chain_r[STAGES-2:0], asyncIn};
    end

    assign syncOut = chain_r[STAGES-1];
endmodule

// [startup_timer.sv]
// counts the start-up window after the comparator is enabled
// assumes enable is a level from the same clock domain
`timescale 1ns/1ns
module startup_timer #(
    parameter int SHORT_CYCLES = 313,
    parameter int LONG_CYCLES  = 7500
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic useLong,
    output logic      settled
);
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        settled_r;
    wire  [15:0] limit = useLong ? 16'(LONG_CYCLES) : 16'(SHORT_CYCLES);
    wire         done  = (count_r >= limit);

    assign count_nxt = !enable ? 16'h0000 : (done ? count_r : count_r + 16'h0001);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r   <= 16'h0000;
            settled_r <= 1'b0;
        end
        else
        begin
            count_r   <= count_nxt;
            settled_r <= enable && done;
        end
    end

    assign settled = settled_r;
endmodule

// [analog_comparator_control.sv]
// digital control and status around one analog voltage comparator
// assumes an asynchronous raw comparator result, a byte register port and
// a sleep state written by software to the sleep control register
// =========================================================================
// Summary of operation
// - result is one when selected positive input exceeds negative, else zero
// - output treated invalid for 2.5 us, or 60 us with internal reference
// - positive picks one of two pins; negative two pins or reference
// - hysteresis off or one of three levels, forwarded to analog core
// - pad output enable drives the result onto the output pad
// - enabled result goes to event routing without resynchronisation
// - block takes no incoming events
// - selected edge of the result sets the compare flag
// - interrupt request is enable and flag, held until flag cleared
// - idle sleep behaves exactly like active mode
// - standby needs run-in-standby; then events, pad and state bit live, flag frozen
// - power-down disables comparator and pad output always
// - debug halt changes nothing
// - edge field: 0 any, 2 falling, 3 rising, 1 reserved
// - writing one clears the flag; writing zero does nothing
// - state bit is the result through a three-stage synchroniser
// - invert bit inverts result for every consumer
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ns
module analog_comparator_control #(
    parameter int STARTUP_CYCLES     = comparator_pkg::STARTUP_CYCLES,
    parameter int REF_STARTUP_CYCLES = comparator_pkg::REF_STARTUP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // analog core
    input  wire logic       rawCompare,
    output logic            analogEnable,
    output logic            positiveInputSelect,
    output logic      [1:0] negativeInputSelect,
    output logic      [1:0] hysteresisSelect,
    output logic            referenceRequest,
    // system
    output logic            compareEvent,
    output logic            padOut,
    output logic            padOutEnable,
    output logic            irqRequest,
    output logic            resultValid
);
    // =====================================================================
    // registers
    logic [7:0] control_r;
    logic [7:0] selector_r;
    logic       irqEnable_r;
    logic       flag_r;
    logic       flag_nxt;
    logic [7:0] sleep_r;
    logic [7:0] rdData_r;
    logic       prevSync_r;
    logic       analogEnable_r;
    logic [1:0] hyst_r;
    logic       posSel_r;
    logic [1:0] negSel_r;
    logic       refReq_r;
    logic       irq_r;

    // =====================================================================
    // field decode
    wire       ctlEnable  = control_r[comparator_pkg::ENABLE_BIT];
    wire [1:0] edgeSel    = control_r[comparator_pkg::EDGE_LSB +: 2];
    wire       padEnable  = control_r[comparator_pkg::PADOUT_BIT];
    wire       runStandby = control_r[comparator_pkg::STANDBY_BIT];
    wire       invert     = selector_r[comparator_pkg::INVERT_BIT];
    wire [1:0] sleepBits  = sleep_r[comparator_pkg::SLEEP_LSB +: 2];

    wire inStandby   = (sleepBits == comparator_pkg::SLEEP_STANDBY);
    wire inPowerDown = (sleepBits == comparator_pkg::SLEEP_POWERDOWN);

    // idle sleep and the debug halt bit take no part in any term below,
    // so the comparator behaves in both exactly as in active mode
    wire running = ctlEnable && !inPowerDown
                   && !(inStandby && !runStandby);
    // the flag and interrupts freeze in standby since the clock is borrowed
    wire statusLive = running && !inStandby;

    // =====================================================================
    // result path: the analog core compares, inversion applies to all users
    // the event path stays combinational so it is never resynchronised
    wire inverted = rawCompare ^ invert;
    wire liveResult = inverted && running;

    // =====================================================================
    // synchroniser and startup window
    logic syncResult;
    logic settled;

    level_synchronizer #(
        .STAGES (comparator_pkg::SYNC_STAGES)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn (liveResult),
        .syncOut (syncResult)
    );

    startup_timer #(
        .SHORT_CYCLES (STARTUP_CYCLES),
        .LONG_CYCLES  (REF_STARTUP_CYCLES)
    ) u_startup (
        .clk     (clk),
        .rst_n   (rst_n),
        .enable  (running),
        .useLong (negSel_r == comparator_pkg::NEG_REF),
        .settled (settled)
    );

    // =====================================================================
    // edge detection on the synchronised copy
    wire rose = syncResult && !prevSync_r;
    wire fell = !syncResult && prevSync_r;
    wire edgeHit = (edgeSel == comparator_pkg::EDGE_ANY)     ? (rose || fell) :
                   (edgeSel == comparator_pkg::EDGE_FALLING) ? fell :
                   (edgeSel == comparator_pkg::EDGE_RISING)  ? rose :
                   1'b0;
    wire setFlag = edgeHit && statusLive;

    // =====================================================================
    // register decode
    wire wrControl  = regWrite && (regAddr == comparator_pkg::COMPARATOR_CONTROL_OFS);
    wire wrSelector = regWrite && (regAddr == comparator_pkg::INPUT_SELECTOR_CONTROL_OFS);
    wire wrIrqEn    = regWrite && (regAddr == comparator_pkg::INTERRUPT_ENABLE_REG_OFS);
    wire wrStatus   = regWrite && (regAddr == comparator_pkg::STATUS_OFS);
    wire wrSleep    = regWrite && (regAddr == comparator_pkg::SLEEP_CONTROL_OFS);
    wire clearFlag  = wrStatus && regWrData[comparator_pkg::FLAG_BIT];
    // the request follows an enable write in the same edge as the register
    wire irqEnable_nxt = wrIrqEn ? regWrData[comparator_pkg::FLAG_BIT] : irqEnable_r;

    // a set in the same cycle as a clear wins so no edge is lost
    assign flag_nxt = setFlag ? 1'b1 : (clearFlag ? 1'b0 : flag_r);

    logic [7:0] statusView;
    logic [7:0] rdMux;

    always_comb
    begin
        statusView = 8'h00;
        statusView[comparator_pkg::STATE_BIT] = syncResult;
        statusView[comparator_pkg::FLAG_BIT]  = flag_r;
    end

    always_comb
    begin
        if (regAddr == comparator_pkg::COMPARATOR_CONTROL_OFS)
            rdMux = control_r;
        else if (regAddr == comparator_pkg::INPUT_SELECTOR_CONTROL_OFS)
            rdMux = selector_r;
        else if (regAddr == comparator_pkg::INTERRUPT_ENABLE_REG_OFS)
            rdMux = {7'h00, irqEnable_r};
        else if (regAddr == comparator_pkg::STATUS_OFS)
            rdMux = statusView;
        else if (regAddr == comparator_pkg::SLEEP_CONTROL_OFS)
            rdMux = sleep_r;
        else
            rdMux = 8'h00;
    end

    // =====================================================================
    // software registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_r   <= comparator_pkg::CONTROL_RESET;
            selector_r  <= comparator_pkg::SELECTOR_RESET;
            irqEnable_r <= 1'b0;
            sleep_r     <= comparator_pkg::SLEEP_RESET;
            rdData_r    <= 8'h00;
        end
        else
        begin
            if (wrControl)
                control_r <= regWrData & comparator_pkg::CONTROL_MASK;
            if (wrSelector)
                selector_r <= regWrData & comparator_pkg::SELECTOR_MASK;
            if (wrIrqEn)
                irqEnable_r <= regWrData[comparator_pkg::FLAG_BIT];
            if (wrSleep)
                sleep_r <= {5'h00, regWrData[2:0]};
            rdData_r <= regRead ? rdMux : 8'h00;
        end
    end

    // =====================================================================
    // status, interrupt and analog control
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_r         <= 1'b0;
            prevSync_r     <= 1'b0;
            irq_r          <= 1'b0;
            analogEnable_r <= 1'b0;
            hyst_r         <= 2'h0;
            posSel_r       <= 1'b0;
            negSel_r       <= comparator_pkg::NEG_PIN0;
            refReq_r       <= 1'b0;
        end
        else
        begin
            flag_r         <= flag_nxt;
            prevSync_r     <= syncResult;
            irq_r          <= irqEnable_nxt && flag_nxt;
            analogEnable_r <= running;
            hyst_r         <= control_r[comparator_pkg::HYST_LSB +: 2];
            posSel_r       <= selector_r[comparator_pkg::POSSEL_BIT];
            negSel_r       <= selector_r[comparator_pkg::NEGSEL_LSB +: 2];
            refReq_r       <= running
                              && (selector_r[comparator_pkg::NEGSEL_LSB +: 2]
                                  == comparator_pkg::NEG_REF);
        end
    end

    // =====================================================================
    // outputs
    // event and pad paths are combinational from the analog result by
    // necessity; the event must not be resynchronised to any clock
    assign compareEvent        = liveResult;
    assign padOut              = liveResult && padEnable;
    assign padOutEnable        = padEnable && running;
    assign regRdData           = rdData_r;
    assign irqRequest          = irq_r;
    assign analogEnable        = analogEnable_r;
    assign hysteresisSelect    = hyst_r;
    assign positiveInputSelect = posSel_r;
    assign negativeInputSelect = negSel_r;
    assign referenceRequest    = refReq_r;
    assign resultValid         = settled;
endmodule

// [analog_comparator_control_chk.sv]
// assertion checker for analog_comparator_control, bound to its ports
// assumes the register offsets and bit positions of comparator_pkg
`timescale 1ns/1ns
module analog_comparator_control_chk #(
    parameter int STARTUP_CYCLES     = 313,
    parameter int REF_STARTUP_CYCLES = 7500
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       rawCompare,
    input wire logic       analogEnable,
    input wire logic [1:0] negativeInputSelect,
    input wire logic       referenceRequest,
    input wire logic       compareEvent,
    input wire logic       padOut,
    input wire logic       padOutEnable,
    input wire logic       irqRequest,
    input wire logic       resultValid
);
    // =====================================================================
    // shadow of the written fields
    logic       invert_r;
    logic [1:0] mode_r;
    int         onCnt_r;
    int         need;
    wire        selWr = regWrite && regAddr == comparator_pkg::INPUT_SELECTOR_CONTROL_OFS;
    wire        slpWr = regWrite && regAddr == comparator_pkg::SLEEP_CONTROL_OFS;
    wire        clrWr = regWrite && (regAddr == comparator_pkg::STATUS_OFS
                        || regAddr == comparator_pkg::INTERRUPT_ENABLE_REG_OFS);
    assign need = (negativeInputSelect == comparator_pkg::NEG_REF) ? REF_STARTUP_CYCLES
                                                                   : STARTUP_CYCLES;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            invert_r <= 1'b0;
            mode_r   <= 2'h0;
            onCnt_r  <= 0;
        end
        else
        begin
            if (selWr)
                invert_r <= regWrData[comparator_pkg::INVERT_BIT];
            if (slpWr)
                mode_r <= regWrData[1:0];
            // saturates well past the longest window so it never wraps
            onCnt_r <= !analogEnable ? 0 : (onCnt_r > 20000) ? onCnt_r : onCnt_r + 1;
        end
    end
    // =====================================================================
    // properties
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_pad;
        padOut |-> padOutEnable && compareEvent;
    endproperty
    a_pad: assert property (p_pad) else $error("pad driven without enable or result");
    property p_irq_hold;
        irqRequest && !clrWr |=> irqRequest;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped on its own");
    property p_ref;
        referenceRequest |-> negativeInputSelect == comparator_pkg::NEG_REF;
    endproperty
    a_ref: assert property (p_ref) else $error("reference asked without select");
    property p_polarity;
        compareEvent |-> rawCompare ^ invert_r;
    endproperty
    a_polarity: assert property (p_polarity) else $error("event polarity wrong");
    property p_powerdown;
        mode_r == 2'h3 && $past(mode_r) == 2'h3 |-> !compareEvent && !padOutEnable;
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("active in power-down");
    property p_standby;
        mode_r == 2'h2 && !regWrite |=> $stable(irqRequest);
    endproperty
    a_standby: assert property (p_standby) else $error("irq moved in standby");
    property p_early;
        resultValid |-> onCnt_r >= need - 2;
    endproperty
    a_early: assert property (p_early) else $error("valid before start-up");
    property p_late;
        onCnt_r == need + 4 |-> resultValid;
    endproperty
    a_late: assert property (p_late) else $error("valid missing after start-up");
endmodule

bind analog_comparator_control analog_comparator_control_chk #(
    .STARTUP_CYCLES(STARTUP_CYCLES), .REF_STARTUP_CYCLES(REF_STARTUP_CYCLES)
) u_analog_comparator_control_chk (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .rawCompare(rawCompare), .analogEnable(analogEnable),
    .negativeInputSelect(negativeInputSelect), .referenceRequest(referenceRequest),
    .compareEvent(compareEvent), .padOut(padOut), .padOutEnable(padOutEnable),
    .irqRequest(irqRequest), .resultValid(resultValid)
);

// [analog_front_model.sv]
// behavioural model of the analog pins, the reference and the comparator core
// assumes pin levels in millivolts from the bench and a free running clock
`timescale 1ns/1ns
module analog_front_model #(
    parameter int REF_MV = 400,
    parameter int SETTLE = 3
) (
    input  wire logic        clk,
    input  wire logic        analogEnable,
    input  wire logic        positiveInputSelect,
    input  wire logic [1:0]  negativeInputSelect,
    input  wire logic [11:0] posMv0,
    input  wire logic [11:0] posMv1,
    input  wire logic [11:0] negMv0,
    input  wire logic [11:0] negMv1,
    output logic             rawCompare
);
    logic [11:0] posMv;
    logic [11:0] negMv;
    logic        wander_r = 1'b0;
    int          up_r = 0;
    assign posMv = positiveInputSelect ? posMv1 : posMv0;
    assign negMv = negativeInputSelect == 2'h0 ? negMv0
                 : negativeInputSelect == 2'h1 ? negMv1 : 12'(REF_MV);
    // pins are purely analog here: no digital input buffer is modelled
    // an unpowered or settling core gives no usable level, so it wanders
    always @(posedge clk)
    begin
        wander_r <= ~wander_r;
        up_r     <= analogEnable ? up_r + 1 : 0;
    end
    assign rawCompare = (analogEnable && up_r >= SETTLE) ? posMv > negMv : wander_r;
endmodule

// [test_analog_comparator_control.sv]
// self-checking bench for analog_comparator_control with the analog front model
// assumes the register map of comparator_pkg and shortened start-up counts
`timescale 1ns/1ns
module test_analog_comparator_control;
    localparam int SHORT = 4;
    localparam int LONG  = 10;
    localparam logic [2:0] CTL = comparator_pkg::COMPARATOR_CONTROL_OFS;
    localparam logic [2:0] SEL = comparator_pkg::INPUT_SELECTOR_CONTROL_OFS;
    localparam logic [2:0] IEN = comparator_pkg::INTERRUPT_ENABLE_REG_OFS;
    localparam logic [2:0] STA = comparator_pkg::STATUS_OFS;
    localparam logic [2:0] SLP = comparator_pkg::SLEEP_CONTROL_OFS;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  regAddr = 3'h0;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regRdData;
    logic        rawCompare, analogEnable, positiveInputSelect, referenceRequest;
    logic [1:0]  negativeInputSelect, hysteresisSelect;
    logic        compareEvent, padOut, padOutEnable, irqRequest, resultValid;
    logic [11:0] posMv0 = 12'h258;
    int          error_cnt = 0;
    int          check_count = 0;
    always #4 clk = ~clk;
    analog_comparator_control #(.STARTUP_CYCLES(SHORT), .REF_STARTUP_CYCLES(LONG))
    u_analog_comparator_control (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .rawCompare(rawCompare), .analogEnable(analogEnable),
        .positiveInputSelect(positiveInputSelect), .negativeInputSelect(negativeInputSelect),
        .hysteresisSelect(hysteresisSelect), .referenceRequest(referenceRequest),
        .compareEvent(compareEvent), .padOut(padOut), .padOutEnable(padOutEnable),
        .irqRequest(irqRequest), .resultValid(resultValid));
    analog_front_model #(.REF_MV(400), .SETTLE(3)) u_analog_front_model (
        .clk(clk), .analogEnable(analogEnable), .positiveInputSelect(positiveInputSelect),
        .negativeInputSelect(negativeInputSelect), .posMv0(posMv0), .posMv1(12'h12c),
        .negMv0(12'h1f4), .negMv1(12'h2bc), .rawCompare(rawCompare));
    // =====================================================================
    // bus and compare helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic lvl(input logic [11:0] mv);
        @(posedge clk);
        posMv0 <= mv;
        wt(10);
    endtask
    // =====================================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] v;
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), v);
            check("reset value", v, 8'h00);
        end
        wr(3'h1, 8'hff);
        rd(3'h1, v);
        check("unmapped read", v, 8'h00);
        for (int h = 0; h < 4; h++)
        begin
            wr(CTL, 8'hf0 | 8'(h << 1));
            rd(CTL, v);
            check("control", v, (8'hf0 | 8'(h << 1)) & comparator_pkg::CONTROL_MASK);
            check("hysteresis", 8'(hysteresisSelect), 8'(h));
            check("off outputs", 8'({compareEvent, padOutEnable, padOut}), 8'h00);
        end
        wr(SEL, 8'hff);
        rd(SEL, v);
        check("selector", v, comparator_pkg::SELECTOR_MASK);
        check("selects", 8'({positiveInputSelect, negativeInputSelect}), 8'h07);
        wr(CTL, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_compare();
        logic [7:0] v;
        logic       e;
        int         pv;
        int         nv;
        for (int i = 0; i < 12; i++)
        begin
            pv = (i % 2) ? 300 : 600;
            nv = ((i / 2) % 3 == 0) ? 500 : ((i / 2) % 3 == 1) ? 700 : 400;
            e = (pv > nv) ^ (i >= 6);
            wr(SEL, {i >= 6, 3'h0, 1'(i % 2), 1'b0, 2'((i / 2) % 3)});
            wr(CTL, 8'h41);
            wt(LONG + 8);
            check("valid", 8'(resultValid), 8'h01);
            check("power", 8'({analogEnable, referenceRequest}), 8'({1'b1, nv == 400}));
            check("event", 8'(compareEvent), 8'(e));
            check("pad", 8'({padOutEnable, padOut}), 8'({1'b1, e}));
            rd(STA, v);
            check("state bit", 8'(v[4]), 8'(e));
            wr(CTL, 8'h40);
            check("off", 8'({compareEvent, padOut}), 8'h00);
        end
        $display("test compare done");
    endtask
    task automatic t_edges();
        logic [7:0] v;
        wr(SEL, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(IEN, 8'(k != 2));
            wr(CTL, 8'h01 | 8'(k << 4));
            wt(20);
            wr(STA, 8'h01);
            lvl(12'h190);
            rd(STA, v);
            check("flag on fall", 8'(v[0]), 8'(k == 0 || k == 2));
            check("irq on fall", 8'(irqRequest), 8'(k == 0));
            wr(STA, 8'h00);
            rd(STA, v);
            check("flag kept", 8'(v[0]), 8'(k == 0 || k == 2));
            wr(STA, 8'h01);
            rd(STA, v);
            check("cleared", 8'({v[0], irqRequest}), 8'h00);
            lvl(12'h258);
            rd(STA, v);
            check("flag on rise", 8'(v[0]), 8'(k == 0 || k == 3));
            wr(STA, 8'h01);
        end
        $display("test edges done");
    endtask
    task automatic t_sleep();
        logic [7:0]      v;
        logic [4:0][7:0] slp = {8'h04, 8'h03, 8'h02, 8'h02, 8'h01};
        logic [4:0][7:0] ctl = {8'hc1, 8'hc1, 8'hc1, 8'h41, 8'h41};
        logic [4:0]      run = 5'h15;
        logic [4:0]      flg = 5'h11;
        wr(IEN, 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            wr(SLP, 8'h00);
            wr(CTL, ctl[i]);
            wt(20);
            wr(STA, 8'h01);
            wr(SLP, slp[i]);
            lvl(12'h190);
            lvl(12'h258);
            check("sleep outs", 8'({compareEvent, padOutEnable, padOut}), 8'({3{run[i]}}));
            check("sleep irq", 8'(irqRequest), 8'(flg[i]));
            rd(STA, v);
            check("sleep flag", 8'(v[0]), 8'(flg[i]));
            wr(SLP, 8'h00);
        end
        $display("test sleep done");
    endtask
    // =====================================================================
    // sequence and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_compare();
        t_edges();
        t_sleep();
        test_done();
    end
    // the whole run needs about 900 cycles; this leaves ample margin
    initial
    begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule
